// File: tts_drv_model.sv
// Stand-in for the electrode drivers: latches each applied row
`timescale 1ns/1ps
module tts_drv_model (
   // Clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // Drive from the sequencer
   input  wire tts_pkg::tts_drive_s drive,
   input  wire logic                row_strobe,
   input  wire logic [7:0]          active_row,
   // Captured row
   output tts_pkg::tts_drive_s      held,
   output logic                     got,
   output logic [7:0]               got_row
);
   // Drive is captured on the strobe; it only changes with the strobe, so between strobes it holds
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held    <= '0;
         got     <= 1'b0;
         got_row <= 8'h00;
      end else begin
         got <= row_strobe;
         if (row_strobe) begin
            held    <= drive;
            got_row <= active_row;
         end
      end
   end
endmodule : tts_drv_model

// File: tts_fifo.sv
// Word FIFO between the register port and the table memory
`timescale 1ns/1ps
module tts_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } tts_fifo_s;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
         $error("tts_fifo: DEPTH must be a power of two, at least 2");
      end
   endgenerate

   logic [W-1:0] mem [DEPTH];
   tts_fifo_s    s, next_s;
   logic         push, pop;

   // Honest flags from the fill count
   assign in_ready  = (s.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s.cnt != '0);
   assign out_data  = mem[s.rp];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointer and count update
   always_comb begin
      next_s = s;
      if (push) next_s.wp = s.wp + 1'b1;
      if (pop) next_s.rp = s.rp + 1'b1;
      next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) s <= '0;
      else s <= next_s;
   end

   // Storage carries no reset; only written words are ever read
   always_ff @(posedge pclk) begin
      if (push) mem[s.wp] <= in_data;
   end
endmodule : tts_fifo

// File: tts_map.svh
// Register map, field positions, reset values and timing constants
`ifndef TTS_MAP_SVH
`define TTS_MAP_SVH
// Register byte offsets
`define TTS_OFS_CTRL    8'h00
`define TTS_OFS_TRIG    8'h04
`define TTS_OFS_PERIOD  8'h08
`define TTS_OFS_MEMORY_TRIGGER_EXPONENT  8'h0c
`define TTS_OFS_LEN     8'h10
`define TTS_OFS_WADDR   8'h14
`define TTS_OFS_WDATA   8'h18
`define TTS_OFS_STATUS  8'h1c
`define TTS_OFS_DWELL   8'h20
// Control field positions
`define TTS_CTRL_TABLE  0
`define TTS_CTRL_SRC_LO 1
`define TTS_CTRL_SRC_HI 3
`define TTS_CTRL_OUTEN  4
`define TTS_CTRL_VOLT   5
`define TTS_CTRL_W      6
// Reset values
`define TTS_CTRL_RST    6'h00
`define TTS_PERIOD_RST  32'h0000_0005
`define TTS_MEMORY_TRIGGER_EXPONENT_RST  5'h00
`define TTS_LEN_RST     9'h001
// Row layout: waveplates, voltages, dwell word
`define TTS_NWP         7
`define TTS_NVOLT       16
`define TTS_ROW_WORDS   24
`define TTS_DWELL_IDX   5'h17
// Timing, in ns, and cycle counts derived from the 4 ns clock
`define TTS_CLK_NS      4
`define TTS_UNIT_NS     40
`define TTS_ATE_NS      80
`define TTS_MIN_NS      200
`define TTS_UNIT_CYC    (`TTS_UNIT_NS / `TTS_CLK_NS)
`define TTS_ATE_CYC     (`TTS_ATE_NS / `TTS_CLK_NS)
`define TTS_MIN_UNITS   (`TTS_MIN_NS / `TTS_UNIT_NS)
`endif

// File: tts_pkg.sv
// Types shared by the table sequencer modules
package tts_pkg;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_DWELL = 2'b11,
      ST_WAIT  = 2'b10
   } tts_seq_e;
   typedef enum logic [2:0] {
      SRC_NONE, SRC_MANUAL, SRC_INTERNAL, SRC_ATE, SRC_EXT, SRC_CONT
   } tts_src_e;
   typedef struct packed {
      logic                volt_mode;
      logic [6:0][15:0]    wp;
      logic [15:0][15:0]   volt;
   } tts_drive_s;
   typedef struct packed {
      logic     out_en;
      tts_src_e src;
   } tts_trig_cfg_s;
   typedef struct packed {
      logic [31:0] cnt;
      logic        ext_q;
      logic        trig_out;
   } tts_tg_state_s;
   typedef struct packed {
      tts_seq_e    seq;
      logic        applied;
      logic        pend;
      logic [7:0]  row;
      logic [4:0]  word;
      logic [31:0] dwell;
      logic [3:0]  presc;
      tts_drive_s  shadow;
      tts_drive_s  drive;
      logic        strobe;
      logic [5:0]  ctrl;
      logic [31:0] period;
      logic [4:0]  memory_trigger_exponent;
      logic [8:0]  len;
      logic [7:0]  wr_row;
      logic [4:0]  wr_word;
      logic        man;
      logic [31:0] rdata;
   } tts_state_s;
endpackage : tts_pkg

// File: tts_sequencer.sv
// Triggered table sequencer with APB register port
`timescale 1ns/1ps
`include "tts_map.svh"
module tts_sequencer #(
   parameter int ROWS  = 64,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic                     pready,
   output logic [31:0]              prdata,
   output logic                     pslverr,
   // Trigger pins
   input  wire logic                ext_trig,
   output logic                     trig_out,
   // Modulator drive
   output tts_pkg::tts_drive_s      drive,
   output logic                     row_strobe,
   output logic [7:0]               active_row
);
   localparam int MW = $clog2(ROWS * `TTS_ROW_WORDS);

   generate
      if (ROWS < 1 || ROWS > 256) begin : g_chk
         $error("tts_sequencer: ROWS must lie in 1..256");
      end
   endgenerate

   // Flat word index of one table entry
   function automatic logic [MW-1:0] addr_of(input logic [7:0] row, input logic [4:0] word);
      addr_of = MW'(row * `TTS_ROW_WORDS + word);
   endfunction : addr_of

   // Dwell in ns to 40 ns units, never zero
   function automatic logic [31:0] units_of(input logic [31:0] ns);
      logic [31:0] u;
      u = ns / 32'(`TTS_UNIT_NS);
      units_of = (u == 32'h0) ? 32'h1 : u;
   endfunction : units_of

   logic [31:0]           tbl [ROWS * `TTS_ROW_WORDS];
   tts_pkg::tts_state_s   s, next_s;
   tts_pkg::tts_trig_cfg_s tcfg;
   tts_pkg::tts_src_e     src;
   logic        acc, wr, mapped, data_wr;
   logic        f_in_ready, f_out_valid, f_out_ready;
   logic [31:0] f_out_data, rd_word;
   logic        trig_gen, trig, table_mode, tick, last_row;
   logic [8:0]  eff_len;
   logic [7:0]  nrow;

   assign src        = tts_pkg::tts_src_e'(s.ctrl[`TTS_CTRL_SRC_HI:`TTS_CTRL_SRC_LO]);
   assign table_mode = s.ctrl[`TTS_CTRL_TABLE];
   assign tcfg       = '{out_en: s.ctrl[`TTS_CTRL_OUTEN], src: src};

   // APB decode; a data write stalls while the FIFO is full
   always_comb begin
      acc = psel & penable;
      unique case (paddr)
         `TTS_OFS_CTRL, `TTS_OFS_TRIG, `TTS_OFS_PERIOD, `TTS_OFS_MEMORY_TRIGGER_EXPONENT, `TTS_OFS_LEN,
         `TTS_OFS_WADDR, `TTS_OFS_WDATA, `TTS_OFS_STATUS, `TTS_OFS_DWELL: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
      data_wr = acc & pwrite & (paddr == `TTS_OFS_WDATA);
      pready  = ~(data_wr & ~f_in_ready);
      pslverr = acc & ~mapped;
      wr      = acc & pwrite & pready & mapped;
   end
   assign prdata = s.rdata;

   tts_fifo #(
      .W     (32),
      .DEPTH (DEPTH)
   ) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (data_wr),
      .in_ready  (f_in_ready),
      .in_data   (pwdata),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   tts_trig_gen #(
      .MAX_EXP (24)
   ) u_trig (
      .pclk     (pclk),
      .presetn  (presetn),
      .cfg      (tcfg),
      .period   (s.period),
      .memory_trigger_exponent   (s.memory_trigger_exponent),
      .manual   (s.man),
      .ext_trig (ext_trig),
      .trig     (trig_gen),
      .trig_out (trig_out)
   );

   // Loader shares the table port, so it yields while a row is fetched
   assign f_out_ready = (s.seq != tts_pkg::ST_FETCH);
   assign rd_word     = tbl[addr_of(s.row, s.word)];

   always_ff @(posedge pclk) begin
      // Widened compare so a full 256-row table still accepts its last row
      if (f_out_valid && f_out_ready && {1'b0, s.wr_row} < 9'(ROWS)) begin
         tbl[addr_of(s.wr_row, s.wr_word)] <= f_out_data;
      end
   end

   // Effective table length and trigger merge
   always_comb begin
      eff_len  = (s.len == 9'h0) ? 9'h1 : ((s.len > 9'(ROWS)) ? 9'(ROWS) : s.len);
      last_row = ({1'b0, s.row} >= eff_len - 9'h1);
      tick     = (s.presc == 4'(`TTS_UNIT_CYC - 1));
      // Continuous source restarts a halted or idle table
      trig = trig_gen | (src == tts_pkg::SRC_CONT & table_mode
                         & (s.seq == tts_pkg::ST_WAIT | s.seq == tts_pkg::ST_IDLE));
      nrow = (!s.applied || last_row) ? 8'h0 : s.row + 8'h1;
   end

   // Next state: registers, loader, sequencer
   always_comb begin
      next_s        = s;
      next_s.strobe = 1'b0;
      next_s.man    = 1'b0;

      // Register writes
      if (wr) begin
         case (paddr)
            `TTS_OFS_CTRL:   next_s.ctrl   = pwdata[`TTS_CTRL_W-1:0];
            `TTS_OFS_TRIG:   next_s.man    = pwdata[0];
            `TTS_OFS_PERIOD: next_s.period = pwdata;
            `TTS_OFS_MEMORY_TRIGGER_EXPONENT: next_s.memory_trigger_exponent = pwdata[4:0];
            `TTS_OFS_LEN:    next_s.len    = pwdata[8:0];
            `TTS_OFS_WADDR: begin
               next_s.wr_row  = pwdata[7:0];
               next_s.wr_word = 5'h0;
            end
            default: ;
         endcase
      end

      // Read data captured in the setup phase
      if (psel && !penable) begin
         case (paddr)
            `TTS_OFS_CTRL:   next_s.rdata = {26'h0, s.ctrl};
            `TTS_OFS_PERIOD: next_s.rdata = s.period;
            `TTS_OFS_MEMORY_TRIGGER_EXPONENT: next_s.rdata = {27'h0, s.memory_trigger_exponent};
            `TTS_OFS_LEN:    next_s.rdata = {23'h0, s.len};
            `TTS_OFS_WADDR:  next_s.rdata = {19'h0, s.wr_word, s.wr_row};
            `TTS_OFS_STATUS: next_s.rdata = {20'h0, s.pend, s.applied, s.seq, s.row};
            `TTS_OFS_DWELL:  next_s.rdata = s.dwell;
            default:         next_s.rdata = 32'h0;
         endcase
      end

      // Loader walks word then row
      if (f_out_valid && f_out_ready) begin
         if (s.wr_word == `TTS_DWELL_IDX) begin
            next_s.wr_word = 5'h0;
            next_s.wr_row  = s.wr_row + 8'h1;
         end else begin
            next_s.wr_word = s.wr_word + 5'h1;
         end
      end

      // Dwell counter in 40 ns units
      next_s.presc = tick ? 4'h0 : s.presc + 4'h1;
      if (tick && s.dwell != 32'h0) next_s.dwell = s.dwell - 32'h1;

      // Set here; the consume below overrides it in the same cycle
      if (trig && !table_mode) next_s.pend = 1'b1;

      case (s.seq)
         tts_pkg::ST_FETCH: begin
            if (s.word < 5'(`TTS_NWP)) begin
               next_s.shadow.wp[3'(s.word)] = rd_word[15:0];
            end else if (s.word < `TTS_DWELL_IDX) begin
               next_s.shadow.volt[4'(s.word - 5'(`TTS_NWP))] = rd_word[15:0];
            end
            next_s.word = s.word + 5'h1;
            if (s.word == `TTS_DWELL_IDX) begin
               // Apply the whole row at once so drivers never see a mix
               next_s.drive           = next_s.shadow;
               next_s.drive.volt_mode = s.ctrl[`TTS_CTRL_VOLT];
               next_s.strobe          = 1'b1;
               next_s.applied         = 1'b1;
               next_s.dwell           = units_of(rd_word);
               next_s.presc           = 4'h0;
               next_s.word            = 5'h0;
               next_s.seq             = table_mode ? tts_pkg::ST_DWELL : tts_pkg::ST_WAIT;
            end
         end
         tts_pkg::ST_DWELL: begin
            if (tick && s.dwell <= 32'h1) begin
               if (last_row) begin
                  next_s.seq = tts_pkg::ST_WAIT;
               end else begin
                  next_s.row = s.row + 8'h1;
                  next_s.seq = tts_pkg::ST_FETCH;
               end
            end
         end
         tts_pkg::ST_IDLE, tts_pkg::ST_WAIT: begin
            // Row mode steps one row per event; a fresh one beside a pending one waits
            if (!table_mode && (s.pend || trig)) begin
               next_s.pend = s.pend & trig;
               next_s.row  = nrow;
               next_s.word = 5'h0;
               next_s.seq  = tts_pkg::ST_FETCH;
            end
         end
         default: next_s.seq = tts_pkg::ST_IDLE;
      endcase

      // Row mode events arriving mid-fetch stay pending
      if (s.seq == tts_pkg::ST_FETCH && trig && !table_mode) next_s.pend = 1'b1;

      // Table mode: any trigger restarts from the first row
      if (trig && table_mode) begin
         next_s.pend = 1'b0;
         next_s.row  = 8'h0;
         next_s.word = 5'h0;
         next_s.seq  = tts_pkg::ST_FETCH;
      end
   end

   // Whole state in one register; idle at row zero with nothing applied
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s        <= '0;
         s.ctrl   <= `TTS_CTRL_RST;
         s.period <= `TTS_PERIOD_RST;
         s.memory_trigger_exponent <= `TTS_MEMORY_TRIGGER_EXPONENT_RST;
         s.len    <= `TTS_LEN_RST;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign drive      = s.drive;
   assign row_strobe = s.strobe;
   assign active_row = s.row;
endmodule : tts_sequencer

// File: tts_sequencer_checker.sv
// Port-level assertions for the table sequencer
`timescale 1ns/1ps
`include "tts_map.svh"
module tts_sequencer_checker #(
   parameter int ROWS = 64
) (
   // Clock and reset
   input wire logic                pclk,
   input wire logic                presetn,
   // APB side
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [7:0]          paddr,
   input wire logic [31:0]         pwdata,
   input wire logic                pready,
   // Triggers and drive
   input wire logic                ext_trig,
   input wire logic                trig_out,
   input wire tts_pkg::tts_drive_s drive,
   input wire logic                row_strobe,
   input wire logic [7:0]          active_row
);
   logic [5:0]  ctrl;
   logic [31:0] per;
   logic [4:0]  mexp;
   logic [8:0]  len;
   logic [7:0]  last;
   logic [31:0] gap;
   logic        seen, any, halt, have;
   wire logic acc = psel && penable && pready && pwrite;
   wire logic ctw = acc && paddr == `TTS_OFS_CTRL;
   wire logic trg = acc && paddr == `TTS_OFS_TRIG && pwdata[0];
   wire logic cfg = ctw || (acc && (paddr == `TTS_OFS_PERIOD || paddr == `TTS_OFS_MEMORY_TRIGGER_EXPONENT));
   wire logic [2:0] src = ctrl[3:1];
   wire logic [8:0] leff = (len == 9'h000) ? 9'h001 : (len > 9'(ROWS)) ? 9'(ROWS) : len;
   wire logic [31:0] per_c = ((per < 32'h5) ? 32'h5 : per) * 32'ha;
   // Shadow of the configuration, kept from the bus writes alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= 6'h00;
         per  <= 32'h5;
         mexp <= 5'h00;
         len  <= 9'h001;
         last <= 8'h00;
         gap  <= 32'h0;
         seen <= 1'b0;
         any  <= 1'b0;
         halt <= 1'b0;
         have <= 1'b0;
      end else begin
         if (ctw) ctrl <= pwdata[5:0];
         if (acc && paddr == `TTS_OFS_PERIOD) per <= pwdata;
         if (acc && paddr == `TTS_OFS_MEMORY_TRIGGER_EXPONENT) mexp <= (pwdata[4:0] > 5'h18) ? 5'h18 : pwdata[4:0];
         if (acc && paddr == `TTS_OFS_LEN) len <= pwdata[8:0];
         if (row_strobe) last <= active_row;
         any  <= any || row_strobe;
         seen <= ctw ? 1'b0 : (seen || (row_strobe && !ctrl[0]));
         // A manual or external trigger, or a control write, releases the halt
         halt <= (trg || ext_trig || ctw) ? 1'b0 : (halt || (row_strobe && ctrl[0] && 9'(active_row) == leff - 9'h1));
         gap  <= trig_out ? 32'h1 : gap + 32'h1;
         have <= cfg ? 1'b0 : (have || trig_out);
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_man_trig;
      trg && ctrl[0] && src == 3'h1;
   endsequence
   sequence s_row0_apply;
      row_strobe && active_row == 8'h00;
   endsequence
   property p_table_restart;
      s_man_trig |-> ##26 s_row0_apply;
   endproperty
   a_table_restart: assert property (p_table_restart) else $error("table trigger missed row zero");
   property p_strobe_pulse;
      row_strobe |=> !row_strobe [*8];
   endproperty
   a_strobe_pulse: assert property (p_strobe_pulse) else $error("row strobe too long");
   property p_drive_hold;
      $changed(drive) |-> row_strobe;
   endproperty
   a_drive_hold: assert property (p_drive_hold) else $error("drive changed without strobe");
   property p_volt_mode;
      row_strobe |-> drive.volt_mode == ctrl[5];
   endproperty
   a_volt_mode: assert property (p_volt_mode) else $error("drive mode differs from control");
   property p_first_row;
      row_strobe && !any |-> active_row == 8'h00;
   endproperty
   a_first_row: assert property (p_first_row) else $error("first row after reset not zero");
   property p_row_step;
      row_strobe && !ctrl[0] && seen |-> active_row == ((9'(last) + 9'h1 >= leff) ? 8'h00 : last + 8'h01);
   endproperty
   a_row_step: assert property (p_row_step) else $error("row mode step wrong");
   property p_table_halt;
      halt && ctrl[0] && src == 3'h1 |-> !row_strobe;
   endproperty
   a_table_halt: assert property (p_table_halt) else $error("row applied while halted");
   property p_int_period;
      trig_out && have && src == 3'h2 |-> gap == per_c;
   endproperty
   a_int_period: assert property (p_int_period) else $error("internal period wrong");
   property p_ate_period;
      trig_out && have && src == 3'h3 |-> gap == (32'h14 << mexp);
   endproperty
   a_ate_period: assert property (p_ate_period) else $error("averaging period wrong");
   property p_trig_out_src;
      trig_out |-> ctrl[4] && (src == 3'h2 || src == 3'h3);
   endproperty
   a_trig_out_src: assert property (p_trig_out_src) else $error("trigger out not enabled");
endmodule : tts_sequencer_checker
bind tts_sequencer tts_sequencer_checker #(.ROWS(ROWS)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .ext_trig(ext_trig),
   .trig_out(trig_out), .drive(drive), .row_strobe(row_strobe), .active_row(active_row));

// File: tts_sequencer_tb_top.sv
// Self-checking bench for the table sequencer
`timescale 1ns/1ps
`include "tts_map.svh"
module tts_sequencer_tb_top;
   localparam int DW = $bits(tts_pkg::tts_drive_s);
   logic                pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic                ext_trig = 1'b0, stalled = 1'b0;
   logic [7:0]          paddr = 8'h00;
   logic [31:0]         pwdata = 32'h0, prdata, rd;
   logic                pready, pslverr, trig_out, row_strobe, got, sl;
   logic [7:0]          active_row, got_row;
   tts_pkg::tts_drive_s drive, held;
   logic [31:0]         tbl [3][24];
   logic [7:0]          exp_row_q [$];
   tts_pkg::tts_drive_s exp_drv_q [$];
   logic [7:0]          ra [5] = '{`TTS_OFS_CTRL, `TTS_OFS_PERIOD, `TTS_OFS_MEMORY_TRIGGER_EXPONENT, `TTS_OFS_LEN, `TTS_OFS_TRIG};
   logic [31:0]         rv [5] = '{32'h0, 32'h5, 32'h0, 32'h1, 32'h0};
   int                  mismatches = 0, checks_done = 0, seed = 92, tocnt = 0;

   tts_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .ext_trig(ext_trig),
      .trig_out(trig_out), .drive(drive), .row_strobe(row_strobe), .active_row(active_row));
   tts_drv_model far (.pclk(pclk), .presetn(presetn), .drive(drive), .row_strobe(row_strobe),
      .active_row(active_row), .held(held), .got(got), .got_row(got_row));

   // 250 MHz clock
   always #2 pclk = ~pclk;

   task automatic chk(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] want);
      checks_done++;
      if (seen !== want) begin
         mismatches++;
         $display("[FAIL] %s expected %0h seen %0h", nm, want, seen);
      end
   endtask : chk

   task automatic end_sim;
      if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   // Psel stays up between back-to-back calls; rel drops it
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      if (psel !== 1'b1) psel <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ready is looked at mid-cycle, so it is the value the next edge samples
      @(negedge pclk);
      while (pready !== 1'b1 && n < 500) begin
         stalled = 1'b1;
         n++;
         @(negedge pclk);
      end
      if (n >= 500) mismatches++;
      rd = prdata;
      sl = pslverr;
      @(posedge pclk);
      penable <= 1'b0;
   endtask : apb

   task automatic rel;
      psel <= 1'b0;
      @(posedge pclk);
   endtask : rel

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      rel();
   endtask : wr

   // Expected rows follow table order, wrapping at three
   task automatic push_n(input int first, input int n, input logic vm);
      tts_pkg::tts_drive_s d;
      int r;
      for (int k = 0; k < n; k++) begin
         r = (first + k) % 3;
         d.volt_mode = vm;
         for (int i = 0; i < 7; i++) d.wp[i] = tbl[r][i][15:0];
         for (int i = 0; i < 16; i++) d.volt[i] = tbl[r][7 + i][15:0];
         exp_row_q.push_back(8'(r));
         exp_drv_q.push_back(d);
      end
   endtask : push_n

   task automatic wait_q(input int left);
      int n;
      n = 0;
      while (exp_row_q.size() > left && n < 3000) begin
         n++;
         @(posedge pclk);
      end
      chk("rows still missing", DW'(exp_row_q.size() > left), DW'(0));
   endtask : wait_q

   // Each applied row is compared with the oldest note
   always @(posedge pclk) begin
      if (trig_out === 1'b1) tocnt++;
      if (got === 1'b1 && exp_row_q.size() == 0) chk("unexpected row", DW'(1), DW'(0));
      else if (got === 1'b1) begin
         chk("row index", DW'(got_row), DW'(exp_row_q.pop_front()));
         chk("row drive", held, exp_drv_q.pop_front());
      end
   end

   // Hang guard, far beyond the expected run of some 4000 cycles
   initial begin
      repeat (50000) @(posedge pclk);
      mismatches++;
      end_sim();
   end

   initial begin
      for (int r = 0; r < 3; r++)
         for (int w = 0; w < 24; w++) tbl[r][w] = $random(seed);
      tbl[0][23] = 32'd200;
      tbl[1][23] = 32'd240;
      tbl[2][23] = 32'd400;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (ra[i]) begin
         apb(1'b0, ra[i], 32'h0);
         rel();
         chk("reset value", DW'(rd), DW'(rv[i]));
      end
      apb(1'b0, 8'h40, 32'h0);
      rel();
      chk("unmapped error", DW'(sl), DW'(1));
      chk("unmapped data", DW'(rd), DW'(0));
      // Load three rows, then row mode with manual triggers in voltage mode
      wr(`TTS_OFS_WADDR, 32'h0);
      for (int r = 0; r < 3; r++)
         for (int w = 0; w < 24; w++) apb(1'b1, `TTS_OFS_WDATA, tbl[r][w]);
      rel();
      wr(`TTS_OFS_LEN, 32'h3);
      wr(`TTS_OFS_CTRL, 32'h22);
      for (int k = 0; k < 4; k++) begin
         push_n(k, 1, 1'b1);
         wr(`TTS_OFS_TRIG, 32'h1);
         // Spare row written during the fetch, when the buffer cannot drain
         if (k == 0) begin
            apb(1'b1, `TTS_OFS_WADDR, 32'h5);
            repeat (16) apb(1'b1, `TTS_OFS_WDATA, $random(seed));
            rel();
         end
         wait_q(0);
      end
      chk("buffer refused", DW'(stalled), DW'(1));
      // Table mode: full run, halt, then restart during row one
      wr(`TTS_OFS_CTRL, 32'h03);
      push_n(0, 3, 1'b0);
      wr(`TTS_OFS_TRIG, 32'h1);
      wait_q(0);
      repeat (300) @(posedge pclk);
      push_n(0, 2, 1'b0);
      wr(`TTS_OFS_TRIG, 32'h1);
      wait_q(0);
      push_n(0, 3, 1'b0);
      wr(`TTS_OFS_TRIG, 32'h1);
      wait_q(0);
      // External source, row mode
      wr(`TTS_OFS_CTRL, 32'h08);
      for (int k = 0; k < 2; k++) begin
         push_n(k, 1, 1'b0);
         ext_trig <= 1'b1;
         repeat (3) @(posedge pclk);
         ext_trig <= 1'b0;
         wait_q(0);
      end
      // Internal source, table mode; period covers the dwell sum
      wr(`TTS_OFS_PERIOD, 32'd40);
      push_n(0, 6, 1'b0);
      wr(`TTS_OFS_CTRL, 32'h15);
      wait_q(0);
      wr(`TTS_OFS_CTRL, 32'h01);
      chk("trigger out pulses", DW'(tocnt), DW'(2));
      // Averaging source, row mode
      wr(`TTS_OFS_MEMORY_TRIGGER_EXPONENT, 32'h1);
      push_n(0, 3, 1'b0);
      wr(`TTS_OFS_CTRL, 32'h16);
      wait_q(0);
      wr(`TTS_OFS_CTRL, 32'h01);
      // Internal source, row mode; period covers the longest dwell
      push_n(0, 2, 1'b0);
      wr(`TTS_OFS_CTRL, 32'h04);
      wait_q(0);
      wr(`TTS_OFS_CTRL, 32'h01);
      // Continuous source; stopping it lets the table finish and halt
      push_n(0, 6, 1'b0);
      wr(`TTS_OFS_CTRL, 32'h0b);
      wait_q(2);
      wr(`TTS_OFS_CTRL, 32'h01);
      wait_q(0);
      repeat (300) @(posedge pclk);
      end_sim();
   end
endmodule : tts_sequencer_tb_top

// File: tts_trig_gen.sv
// Trigger source selection and periodic trigger generators
`timescale 1ns/1ps
`include "tts_map.svh"
module tts_trig_gen #(
   parameter int MAX_EXP = 24
) (
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // Configuration
   input  wire tts_pkg::tts_trig_cfg_s cfg,
   input  wire logic [31:0]           period,
   input  wire logic [4:0]            memory_trigger_exponent,
   // Trigger inputs
   input  wire logic                  manual,
   input  wire logic                  ext_trig,
   // Trigger outputs
   output logic                       trig,
   output logic                       trig_out
);
   generate
      if (MAX_EXP < 0 || MAX_EXP > 26) begin : g_chk
         $error("tts_trig_gen: MAX_EXP must lie in 0..26");
      end
   endgenerate

   tts_pkg::tts_tg_state_s s, next_s;
   logic [31:0] units, target;
   logic [4:0]  e;
   logic        gen, fire;

   // Shortest period clamped to the documented minimum
   always_comb begin
      units = (period < 32'(`TTS_MIN_UNITS)) ? 32'(`TTS_MIN_UNITS) : period;
      e     = (memory_trigger_exponent > 5'(MAX_EXP)) ? 5'(MAX_EXP) : memory_trigger_exponent;
      gen   = 1'b0;
      target = 32'(`TTS_UNIT_CYC) * units;
      if (cfg.src == tts_pkg::SRC_ATE) target = 32'(`TTS_ATE_CYC) << e;
      if (cfg.src == tts_pkg::SRC_INTERNAL || cfg.src == tts_pkg::SRC_ATE) gen = 1'b1;
      fire = gen & (s.cnt >= target - 32'h1);
   end

   // Count runs only while a periodic source is selected, held at zero otherwise, restarted on each fire
   always_comb begin
      next_s          = s;
      next_s.ext_q    = ext_trig;
      next_s.cnt      = (fire || !gen) ? 32'h0 : s.cnt + 32'h1;
      next_s.trig_out = cfg.out_en & fire;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) s <= '0;
      else s <= next_s;
   end

   // One pulse per event from whichever source is selected
   assign trig = fire
               | (manual & (cfg.src == tts_pkg::SRC_MANUAL))
               | (ext_trig & ~s.ext_q & (cfg.src == tts_pkg::SRC_EXT));
   assign trig_out = s.trig_out;
endmodule : tts_trig_gen
